// [src/nbl_pkg.sv]
`default_nettype none
package nbl_pkg;
	// ************************************************************
	// Timing, all at 100 MHz
	// ************************************************************
	localparam int NBL_CLK_NS = 10;
	localparam int NBL_TCLS_NS = 10;
	localparam int NBL_TWP_NS = 12;
	localparam int NBL_TWH_NS = 10;
	localparam int NBL_TADL_NS = 70;
	localparam int NBL_SETUP_CYC = (NBL_TCLS_NS + NBL_CLK_NS - 1) / NBL_CLK_NS;
	localparam int NBL_LOW_CYC = (NBL_TWP_NS + NBL_CLK_NS - 1) / NBL_CLK_NS;
	localparam int NBL_HIGH_CYC = (NBL_TWH_NS + NBL_CLK_NS - 1) / NBL_CLK_NS;
	localparam int NBL_ADL_CYC = (NBL_TADL_NS + NBL_CLK_NS - 1) / NBL_CLK_NS;

	// ************************************************************
	// Own register map, reset values and fields
	// ************************************************************
	localparam logic [7:0] NBL_OFS_CTRL = 8'h00;
	localparam logic [7:0] NBL_OFS_ADDR0 = 8'h04;
	localparam logic [7:0] NBL_OFS_ADDR1 = 8'h08;
	localparam logic [7:0] NBL_OFS_FEAT = 8'h0C;
	localparam logic [7:0] NBL_OFS_DATA = 8'h10;
	localparam logic [7:0] NBL_OFS_STAT = 8'h14;
	localparam int NBL_CTRL_START = 8;
	localparam int NBL_CTRL_WP = 16;
	localparam logic [7:0] NBL_FEAT_RST = 8'h38;
	localparam int NBL_PLANE_BIT = 18;

	// ************************************************************
	// Device command and feature bytes
	// ************************************************************
	localparam logic [7:0] NBL_CMD_PROG = 8'h80;
	localparam logic [7:0] NBL_CMD_PLANE = 8'h11;
	localparam logic [7:0] NBL_CMD_CONF = 8'h10;
	localparam logic [7:0] NBL_CMD_CACHE = 8'h15;
	localparam logic [7:0] NBL_CMD_RAND = 8'h85;
	localparam logic [7:0] NBL_CMD_ERASE = 8'h60;
	localparam logic [7:0] NBL_CMD_ER_PL = 8'hD1;
	localparam logic [7:0] NBL_CMD_ER_GO = 8'hD0;
	localparam logic [7:0] NBL_CMD_SETF = 8'hEF;
	localparam logic [7:0] NBL_CMD_GETF = 8'hEE;
	localparam logic [7:0] NBL_CMD_STAT = 8'h70;
	localparam logic [7:0] NBL_CMD_ESTAT = 8'h78;
	localparam logic [7:0] NBL_FADDR_PROT = 8'hA0;
	localparam logic [7:0] NBL_STAT_PROT = 8'h60;

	// Operations software may start
	localparam logic [3:0] NBL_OP_PROG = 4'h1;
	localparam logic [3:0] NBL_OP_CACHE = 4'h2;
	localparam logic [3:0] NBL_OP_PRAND = 4'h3;
	localparam logic [3:0] NBL_OP_ERASE = 4'h4;
	localparam logic [3:0] NBL_OP_SETF = 4'h5;
	localparam logic [3:0] NBL_OP_GETF = 4'h6;
	localparam logic [3:0] NBL_OP_STAT = 4'h7;
	localparam logic [3:0] NBL_OP_ESTAT = 4'h8;

	// Sequence step kinds
	typedef enum logic [2:0] {
		NBL_K_END, NBL_K_CMD, NBL_K_ADR, NBL_K_LIT, NBL_K_DAT, NBL_K_GAP, NBL_K_WAIT, NBL_K_RD
	} nbl_kind_t;

	// Bus cycle kinds for the pin driver
	typedef enum logic [1:0] {NBL_C_CMD, NBL_C_ADR, NBL_C_DIN, NBL_C_DOUT} nbl_cyc_t;
endpackage : nbl_pkg
`default_nettype wire

// [src/nbl_cycle.sv]
`default_nettype none
// One latch cycle on the flash pins: setup, strobe low, strobe high
module nbl_cycle import nbl_pkg::*; #(
	parameter int RD_LOW_CYC = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire nbl_cyc_t kind,
	input wire logic [7:0] wbyte,
	input wire logic [7:0] io_in,
	output logic done,
	output logic [7:0] rbyte,
	output logic cle,
	output logic ale,
	output logic we_n,
	output logic re_n,
	output logic [7:0] io_out,
	output logic io_oe
);
	typedef enum logic [1:0] {NBL_P_IDLE, NBL_P_SET, NBL_P_LOW, NBL_P_HIGH} nbl_ph_t;
	nbl_ph_t ph_r;
	logic [3:0] cnt_r;
	logic rd_r;
	wire last = (cnt_r == 4'h0);

	// ************************************************************
	// Phase sequencer; latches hold until the strobe has risen
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph_r <= NBL_P_IDLE;
			cnt_r <= 4'h0;
			rd_r <= 1'b0;
			done <= 1'b0;
			rbyte <= 8'h00;
			cle <= 1'b0;
			ale <= 1'b0;
			we_n <= 1'b1;
			re_n <= 1'b1;
			io_out <= 8'h00;
			io_oe <= 1'b0;
		end else begin
			done <= 1'b0;
			case (ph_r)
				NBL_P_IDLE: if (start) begin
					cle <= (kind == NBL_C_CMD);
					ale <= (kind == NBL_C_ADR);
					rd_r <= (kind == NBL_C_DOUT);
					io_out <= wbyte;
					io_oe <= (kind != NBL_C_DOUT); // Never fight the device on reads
					cnt_r <= 4'(NBL_SETUP_CYC - 1);
					ph_r <= NBL_P_SET;
				end
				NBL_P_SET: if (last) begin
					we_n <= rd_r;
					re_n <= !rd_r;
					cnt_r <= rd_r ? 4'(RD_LOW_CYC - 1) : 4'(NBL_LOW_CYC - 1);
					ph_r <= NBL_P_LOW;
				end else cnt_r <= cnt_r - 4'h1;
				NBL_P_LOW: if (last) begin
					we_n <= 1'b1;
					re_n <= 1'b1;
					if (rd_r) rbyte <= io_in;
					cnt_r <= 4'(NBL_HIGH_CYC - 1);
					ph_r <= NBL_P_HIGH;
				end else cnt_r <= cnt_r - 4'h1;
				default: if (last) begin
					cle <= 1'b0;
					ale <= 1'b0;
					io_oe <= 1'b0;
					done <= 1'b1;
					ph_r <= NBL_P_IDLE;
				end else cnt_r <= cnt_r - 4'h1;
			endcase
		end
	end
endmodule : nbl_cycle
`default_nettype wire

// [src/nbl_host.sv]
// Our own choices: the APB interface to the registers and the placing of the registers.
`default_nettype none
// What this block does
// - Host unprotects blocks with set-feature to address A0h plus protection byte.
// - Host drives write-protect high before any protection set-feature.
// - Both planes run the same operation type; no mixing.
// - Host gives the two planes differing plane-select address bits.
// - Host gives both planes identical page address bits.
// - Two-plane program: first plane 80h-11h, final plane 80h-10h.
// - Two-plane cache program: two-plane sequence closed with 80h-15h.
// - Two-plane erase: 60h-D1h for first block, 60h-D0h for second.
module nbl_host import nbl_pkg::*; #(
	parameter int DATA_BYTES = 2112,
	parameter int WB_CYC = 10,
	parameter int RD_LOW_CYC = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic ce_n,
	output logic cle,
	output logic ale,
	output logic we_n,
	output logic re_n,
	output logic wp_n,
	output logic [7:0] io_out,
	output logic io_oe,
	input wire logic [7:0] io_in,
	input wire logic rb_n
);
	typedef enum logic [2:0] {NBL_S_IDLE, NBL_S_STEP, NBL_S_CYC, NBL_S_CNT, NBL_S_RB} nbl_st_t;

	// ************************************************************
	// Sequence table: one step is {kind, argument}
	// ************************************************************
	function automatic logic [10:0] st(input nbl_kind_t k, input logic [7:0] a);
		st = {k, a};
	endfunction : st

	function automatic logic [10:0] step(input logic [3:0] op, input logic [4:0] i);
		logic pr;
		pr = (op == NBL_OP_PRAND);
		step = st(NBL_K_END, 8'h00);
		if (op == NBL_OP_PROG || op == NBL_OP_CACHE || pr) begin
			case (i)
				5'd0: step = st(NBL_K_CMD, NBL_CMD_PROG);
				5'd1, 5'd2, 5'd3, 5'd4, 5'd5: step = st(NBL_K_ADR, 8'(i - 5'd1));
				5'd6, 5'd11: step = st(NBL_K_GAP, 8'h00);
				5'd7, 5'd12: step = st(NBL_K_DAT, 8'h00);
				5'd8: step = pr ? st(NBL_K_CMD, NBL_CMD_RAND) : st(NBL_K_GAP, 8'h00);
				5'd9, 5'd10: step = pr ? st(NBL_K_ADR, 8'(i - 5'd9)) : st(NBL_K_GAP, 8'h00);
				5'd13: step = st(NBL_K_CMD, NBL_CMD_PLANE);
				5'd14, 5'd24: step = st(NBL_K_WAIT, 8'h00);
				5'd15: step = st(NBL_K_CMD, NBL_CMD_PROG);
				5'd16, 5'd17, 5'd18, 5'd19, 5'd20: step = st(NBL_K_ADR, 8'h10 | 8'(i - 5'd16));
				5'd21: step = st(NBL_K_GAP, 8'h00);
				5'd22: step = st(NBL_K_DAT, 8'h00);
				// Cache variant closes with 15h; software ends the chain with a plain one
				5'd23: step = st(NBL_K_CMD, op == NBL_OP_CACHE ? NBL_CMD_CACHE : NBL_CMD_CONF);
				5'd25: step = st(NBL_K_CMD, NBL_CMD_STAT);
				5'd26: step = st(NBL_K_RD, 8'h00);
				default: step = st(NBL_K_END, 8'h00);
			endcase
		end else if (op == NBL_OP_ERASE) begin
			case (i)
				5'd0, 5'd6: step = st(NBL_K_CMD, NBL_CMD_ERASE);
				5'd1, 5'd2, 5'd3: step = st(NBL_K_ADR, 8'(i + 5'd1));
				5'd4: step = st(NBL_K_CMD, NBL_CMD_ER_PL);
				5'd5, 5'd11: step = st(NBL_K_WAIT, 8'h00);
				5'd7, 5'd8, 5'd9: step = st(NBL_K_ADR, 8'h10 | 8'(i - 5'd5));
				5'd10: step = st(NBL_K_CMD, NBL_CMD_ER_GO);
				5'd12: step = st(NBL_K_CMD, NBL_CMD_STAT);
				5'd13: step = st(NBL_K_RD, 8'h00);
				default: step = st(NBL_K_END, 8'h00);
			endcase
		end else if (op == NBL_OP_SETF) begin
			case (i)
				5'd0: step = st(NBL_K_CMD, NBL_CMD_SETF);
				5'd1: step = st(NBL_K_LIT, NBL_FADDR_PROT);
				5'd2: step = st(NBL_K_GAP, 8'h00);
				5'd3: step = st(NBL_K_DAT, 8'h01);
				5'd4, 5'd5, 5'd6: step = st(NBL_K_DAT, 8'h02);
				5'd7: step = st(NBL_K_WAIT, 8'h00);
				default: step = st(NBL_K_END, 8'h00);
			endcase
		end else if (op == NBL_OP_GETF) begin
			case (i)
				5'd0: step = st(NBL_K_CMD, NBL_CMD_GETF);
				5'd1: step = st(NBL_K_LIT, NBL_FADDR_PROT);
				5'd2: step = st(NBL_K_WAIT, 8'h00);
				5'd3: step = st(NBL_K_RD, 8'h01);
				default: step = st(NBL_K_END, 8'h00);
			endcase
		end else if (op == NBL_OP_STAT || op == NBL_OP_ESTAT) begin
			case (i)
				5'd0: step = st(NBL_K_CMD, op == NBL_OP_STAT ? NBL_CMD_STAT : NBL_CMD_ESTAT);
				5'd1: step = op == NBL_OP_STAT ? st(NBL_K_RD, 8'h00) : st(NBL_K_ADR, 8'h02);
				5'd2, 5'd3: step = op == NBL_OP_STAT ? st(NBL_K_END, 8'h00) : st(NBL_K_ADR, 8'(i + 5'd1));
				5'd4: step = op == NBL_OP_STAT ? st(NBL_K_END, 8'h00) : st(NBL_K_RD, 8'h00);
				default: step = st(NBL_K_END, 8'h00);
			endcase
		end
	endfunction : step

	// ************************************************************
	// Registers
	// ************************************************************
	logic [3:0] op_r;
	logic wp_r, busy_r, done_r;
	logic [28:0] addr0_r, addr1_r;
	logic [7:0] feat_r, data_r, stat_r, getf_r;
	nbl_st_t state_r;
	logic [4:0] idx_r;
	logic [15:0] cnt_r;
	logic [7:0] rd_dst_r;
	logic cyc_start_r;
	nbl_cyc_t cyc_kind_r;
	logic [7:0] cyc_byte_r;
	logic cyc_done;
	logic [7:0] cyc_rbyte;

	// Second-plane address: plane bit forced opposite, page copied, block kept
	wire [28:0] plane1_addr = {addr1_r[28:19], ~addr0_r[NBL_PLANE_BIT], addr0_r[17:12],
		addr1_r[11:0]};
	wire [10:0] cur = step(op_r, idx_r);
	wire nbl_kind_t cur_kind = nbl_kind_t'(cur[10:8]);
	wire [7:0] cur_arg = cur[7:0];
	wire [28:0] sel_addr = cur_arg[4] ? plane1_addr : addr0_r;
	wire [7:0] adr_byte = (cur_arg[2:0] == 3'd0) ? sel_addr[7:0] :
		(cur_arg[2:0] == 3'd1) ? {4'h0, sel_addr[11:8]} :
		(cur_arg[2:0] == 3'd2) ? sel_addr[19:12] :
		(cur_arg[2:0] == 3'd3) ? sel_addr[27:20] : {7'h00, sel_addr[28]};
	wire [7:0] dat_byte = (cur_arg == 8'h01) ? feat_r : (cur_arg == 8'h02) ? 8'h00 : data_r;

	// APB decode, zero-wait slave
	wire acc = psel && penable;
	wire wr = acc && pwrite;
	wire hit_ctrl = (paddr == NBL_OFS_CTRL);
	wire hit_a0 = (paddr == NBL_OFS_ADDR0);
	wire hit_a1 = (paddr == NBL_OFS_ADDR1);
	wire hit_feat = (paddr == NBL_OFS_FEAT);
	wire hit_data = (paddr == NBL_OFS_DATA);
	wire hit_stat = (paddr == NBL_OFS_STAT);
	wire mapped = hit_ctrl || hit_a0 || hit_a1 || hit_feat || hit_data || hit_stat;
	wire go = wr && hit_ctrl && pwdata[NBL_CTRL_START] && !busy_r;
	wire [31:0] rd_val = hit_ctrl ? {15'h0, wp_r, 7'h0, busy_r, 4'h0, op_r} :
		hit_a0 ? {3'h0, addr0_r} : hit_a1 ? {3'h0, addr1_r} :
		hit_feat ? {24'h0, feat_r} : hit_data ? {24'h0, data_r} :
		hit_stat ? {7'h0, (stat_r == NBL_STAT_PROT), getf_r, stat_r, 6'h0, done_r, busy_r} :
		32'h0;

	// ************************************************************
	// Register bus process
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			op_r <= 4'h0;
			wp_r <= 1'b0;
			addr0_r <= 29'h0;
			addr1_r <= 29'h0;
			feat_r <= NBL_FEAT_RST;
			data_r <= 8'h00;
		end else begin
			pready <= psel && !penable; // Answer lands on the first access cycle
			pslverr <= psel && !penable && !mapped;
			prdata <= (psel && !penable && !pwrite) ? rd_val : 32'h0;
			if (wr && hit_ctrl) wp_r <= pwdata[NBL_CTRL_WP];
			if (go) op_r <= pwdata[3:0];
			if (wr && hit_a0) addr0_r <= pwdata[28:0];
			if (wr && hit_a1) addr1_r <= pwdata[28:0];
			if (wr && hit_feat) feat_r <= pwdata[7:0];
			if (wr && hit_data) data_r <= pwdata[7:0];
		end
	end

	// ************************************************************
	// Sequencer; one op at a time so both planes share a type
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= NBL_S_IDLE;
			idx_r <= 5'h0;
			cnt_r <= 16'h0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
			stat_r <= 8'h00;
			getf_r <= 8'h00;
			rd_dst_r <= 8'h00;
			cyc_start_r <= 1'b0;
			cyc_kind_r <= NBL_C_CMD;
			cyc_byte_r <= 8'h00;
			ce_n <= 1'b1;
			wp_n <= 1'b0;
		end else begin
			cyc_start_r <= 1'b0;
			wp_n <= wp_r || busy_r; // Raised one cycle after ce_n falls, ahead of the first cycle
			case (state_r)
				NBL_S_IDLE: if (go) begin
					busy_r <= 1'b1;
					done_r <= 1'b0;
					idx_r <= 5'h0;
					ce_n <= 1'b0;
					state_r <= NBL_S_STEP;
				end
				NBL_S_STEP: begin
					idx_r <= idx_r + 5'h1;
					cnt_r <= 16'(DATA_BYTES - 1);
					// A wait step is marked here; the index has already moved on by the count
					rd_dst_r <= (cur_kind == NBL_K_WAIT) ? 8'hFF : cur_arg;
					cyc_byte_r <= (cur_kind == NBL_K_ADR) ? adr_byte :
						(cur_kind == NBL_K_DAT) ? dat_byte : cur_arg;
					cyc_kind_r <= (cur_kind == NBL_K_CMD) ? NBL_C_CMD :
						(cur_kind == NBL_K_DAT) ? NBL_C_DIN :
						(cur_kind == NBL_K_RD) ? NBL_C_DOUT : NBL_C_ADR;
					case (cur_kind)
						NBL_K_END: begin
							busy_r <= 1'b0;
							done_r <= 1'b1;
							ce_n <= 1'b1;
							state_r <= NBL_S_IDLE;
						end
						NBL_K_GAP: begin
							cnt_r <= 16'(NBL_ADL_CYC - 1);
							state_r <= NBL_S_CNT;
						end
						NBL_K_WAIT: begin // Busy low can last up to 2.5 us on a reject
							cnt_r <= 16'(WB_CYC - 1);
							state_r <= NBL_S_CNT;
						end
						default: begin
							if (cur_kind == NBL_K_DAT && cur_arg != 8'h00) cnt_r <= 16'h0;
							if (cur_kind != NBL_K_DAT) cnt_r <= 16'h0;
							cyc_start_r <= 1'b1;
							state_r <= NBL_S_CYC;
						end
					endcase
					if (cur_kind == NBL_K_WAIT || cur_kind == NBL_K_GAP) idx_r <= idx_r + 5'h1;
				end
				NBL_S_CYC: if (cyc_done) begin
					if (cyc_kind_r == NBL_C_DOUT && rd_dst_r == 8'h00) stat_r <= cyc_rbyte;
					if (cyc_kind_r == NBL_C_DOUT && rd_dst_r == 8'h01) getf_r <= cyc_rbyte;
					if (cnt_r == 16'h0) state_r <= NBL_S_STEP;
					else begin
						cnt_r <= cnt_r - 16'h1; // Page data burst repeats the data byte
						cyc_start_r <= 1'b1;
					end
				end
				NBL_S_CNT: if (cnt_r == 16'h0) begin
					state_r <= (rd_dst_r == 8'hFF) ? NBL_S_RB : NBL_S_STEP;
				end else cnt_r <= cnt_r - 16'h1;
				default: if (rb_n) state_r <= NBL_S_STEP; // Ready again
			endcase
		end
	end

	// ************************************************************
	// Pin driver
	// ************************************************************
	nbl_cycle #(.RD_LOW_CYC(RD_LOW_CYC)) u_cyc (
		.pclk(pclk),
		.presetn(presetn),
		.start(cyc_start_r),
		.kind(cyc_kind_r),
		.wbyte(cyc_byte_r),
		.io_in(io_in),
		.done(cyc_done),
		.rbyte(cyc_rbyte),
		.cle(cle),
		.ale(ale),
		.we_n(we_n),
		.re_n(re_n),
		.io_out(io_out),
		.io_oe(io_oe)
	);
endmodule : nbl_host
`default_nettype wire

// [dv/nbl_host_asserts.sv]
`default_nettype none
// ****
// Port checker for the flash host
// ****
module nbl_host_asserts import nbl_pkg::*; #(
	parameter int RD_LOW_CYC = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic ce_n,
	input wire logic cle,
	input wire logic ale,
	input wire logic we_n,
	input wire logic re_n,
	input wire logic wp_n,
	input wire logic [7:0] io_out,
	input wire logic io_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Strobe shapes, the read one sized for the simulated low time of three
	sequence s_we_pulse;
		!we_n ##1 we_n;
	endsequence
	sequence s_re_pulse;
		!re_n [*2] ##1 re_n;
	endsequence
	AST_RDY_ZERO_WAIT: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	AST_RDY_PULSE: assert property (pready |=> !pready)
		else $error("pready held two cycles");
	AST_ERR_WITH_RDY: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_CLE_ALE_EXCL: assert property (!(cle && ale))
		else $error("command and address latch together");
	AST_STROBE_SELECTED: assert property (!we_n || !re_n |-> !ce_n)
		else $error("strobe while deselected");
	AST_WE_WIDTH: assert property ($fell(we_n) |=> s_we_pulse)
		else $error("write strobe width wrong");
	AST_RE_WIDTH: assert property ($fell(re_n) |=> s_re_pulse)
		else $error("read strobe width wrong");
	AST_LATCH_HOLD: assert property (!we_n |-> $stable(io_out) && $stable(cle) && $stable(ale))
		else $error("latch value moved under strobe");
	AST_NO_DRIVE_ON_READ: assert property (!re_n |-> !io_oe)
		else $error("bus driven during read strobe");
	AST_WP_HIGH_ON_WRITE: assert property (!we_n |-> wp_n)
		else $error("write strobe with protect low");
	AST_START_OP: assert property (psel && penable && pready && pwrite && paddr == NBL_OFS_CTRL
		&& pwdata[NBL_CTRL_START] && ce_n |-> ##[1:2] !ce_n)
		else $error("start did not select device");
endmodule : nbl_host_asserts
bind nbl_host nbl_host_asserts #(.RD_LOW_CYC(RD_LOW_CYC)) nbl_host_asserts_i (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .pslverr(pslverr), .ce_n(ce_n), .cle(cle), .ale(ale),
	.we_n(we_n), .re_n(re_n), .wp_n(wp_n), .io_out(io_out), .io_oe(io_oe));
`default_nettype wire

// [dv/nbl_flash_model.sv]
`default_nettype none
// ****
// Behavioural flash device with block protection
// ****
module nbl_flash_model #(
	parameter logic STRAP = 1'b1
) (
	input wire logic ce_n,
	input wire logic cle,
	input wire logic ale,
	input wire logic we_n,
	input wire logic re_n,
	input wire logic wp_n,
	input wire logic [7:0] io_out,
	output logic [7:0] io_in,
	output logic rb_n,
	output logic [7:0] errs
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cmd, faddr, st, out, feat;
	logic [23:0] row;
	logic [5:0] pg;
	logic pend, rej, kind, p0;
	int ac, dc;
	// Power-on state; protection byte starts all locked
	initial begin
		feat = 8'h38;
		st = 8'h00; out = 8'h00; rb_n = 1'b1; errs = 8'h00; pend = 0; rej = 0; kind = 0;
	end
	// Released bus shows the inverse so a stale byte cannot pass
	assign io_in = (!ce_n && !re_n) ? out : ~out;
	// Locked-region decode from lock size, invert and complementary
	function automatic logic prot(input logic [10:0] b);
		logic [10:0] hi;
		logic sel;
		if (!STRAP || feat[5:3] == 3'h0) return 1'b0;
		if (feat[5:3] == 3'h7) return 1'b1;
		hi = b >> (4 + feat[5:3]);
		sel = feat[2] ? (hi == 11'h000) : (hi == (11'h7FF >> (4 + feat[5:3])));
		return feat[1] ? ((feat[5:3] == 3'h6) ? (b == 11'h000) : !sel) : sel;
	endfunction : prot
	task automatic busy(input int ns);
		rb_n = 1'b0;
		rb_n <= #(ns) 1'b1;
	endtask : busy
	// Latch on the rising write strobe
	always @(posedge we_n) if (!ce_n) begin
		if (cle) begin
			ac = 0;
			dc = 0;
			case (io_out)
				8'h80, 8'h60: begin
					if (pend && kind != (io_out == 8'h60)) errs++;
					kind = (io_out == 8'h60);
					cmd = io_out;
				end
				8'h11, 8'hD1: begin
					rej = rej | prot(row[16:6]);
					pend = 1;
					p0 = row[6];
					pg = row[5:0];
					busy(500);
				end
				8'h10, 8'h15, 8'hD0: begin
					rej = rej | prot(row[16:6]);
					if (!pend || row[6] == p0 || row[5:0] != pg) errs++;
					pend = 0;
					st = rej ? 8'h60 : 8'h00;
					busy(rej ? 2500 : 800);
					rej = 0;
				end
				8'h70, 8'h78: begin
					cmd = io_out;
					out = st;
				end
				8'h85: cmd = io_out;
				default: cmd = io_out;
			endcase
		end else if (ale) begin
			if (cmd == 8'h80 && ac >= 2) row[(ac - 2) * 8 +: 8] = io_out;
			if (cmd == 8'h60 || cmd == 8'h78) row[ac * 8 +: 8] = io_out;
			if (cmd == 8'hEE || cmd == 8'hEF) faddr = io_out;
			if (cmd == 8'hEE) out = (STRAP && io_out == 8'hA0) ? feat : 8'h00;
			ac++;
		end else begin
			// Solid lock freezes the byte until power cycles
			if (cmd == 8'hEF && dc == 0 && faddr == 8'hA0 && STRAP && wp_n && !feat[0])
				feat = io_out;
			dc++;
		end
	end
endmodule : nbl_flash_model
`default_nettype wire

// [dv/nbl_host_test.sv]
`default_nettype none
module nbl_host_test import nbl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ce_n, cle, ale;
	logic we_n, re_n, wp_n, io_oe, rb_n;
	logic [7:0] paddr, io_out, io_in, perr;
	logic [31:0] pwdata, prdata, rd, r;
	logic [32:0] mq[$], vq[$], em, ev;
	int mismatches, checked, seed, cyc, i;
	nbl_host #(.DATA_BYTES(4), .WB_CYC(2), .RD_LOW_CYC(3)) nbl_host_i (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ce_n(ce_n),
		.cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .io_out(io_out),
		.io_oe(io_oe), .io_in(io_in), .rb_n(rb_n));
	nbl_flash_model #(.STRAP(1'b1)) nbl_flash_model_i (.ce_n(ce_n), .cle(cle), .ale(ale),
		.we_n(we_n), .re_n(re_n), .wp_n(wp_n), .io_out(io_out), .io_in(io_in), .rb_n(rb_n),
		.errs(perr));
	// ****
	// Clock, timeout and result watcher
	// ****
	initial begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			mismatches++;
			test_done();
		end
	end
	// Oldest note is matched against each completed read
	always @(posedge pclk) if (psel && penable && pready === 1'b1 && !pwrite) begin
		em = mq.pop_front();
		ev = vq.pop_front();
		if (em !== 33'h0) begin
			checked++;
			if (({pslverr, prdata} & em) !== ev) begin
				mismatches++;
				$display("ERROR reg %h exp %h got %h", paddr, ev, {pslverr, prdata} & em);
			end
		end
	end
	// ****
	// Bus tasks
	// ****
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] m, input logic [32:0] v);
		if (!w) begin
			mq.push_back(m);
			vq.push_back(v);
		end
		// One idle edge between transfers, so psel is never set twice in one step
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the bench timeout ends a wait for the answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Start with protect high, wait for done, then check the status word
	task automatic op(input logic [3:0] o, input logic [31:0] m, input logic [31:0] v);
		apb(1'b1, NBL_OFS_CTRL, 32'h0001_0100 | {28'h0, o}, 33'h0, 33'h0);
		// A hang here is caught by the cycle ceiling, which counts a mismatch
		do begin
			apb(1'b0, NBL_OFS_STAT, 32'h0, 33'h0, 33'h0);
		end while (rd[1:0] !== 2'b10);
		apb(1'b0, NBL_OFS_STAT, 32'h0, {1'b0, m}, {1'b0, v});
		$display("test op %h done", o);
	endtask : op
	task automatic setf(input logic [7:0] p);
		apb(1'b1, NBL_OFS_FEAT, {24'h0, p}, 33'h0, 33'h0);
		op(NBL_OP_SETF, 32'h0, 32'h0);
	endtask : setf
	task test_done;
		$display("counts checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done
	// ****
	// Main sequence
	// ****
	initial begin
		seed = 48;
		psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0; presetn = 0;
		mismatches = 0; checked = 0; cyc = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, NBL_OFS_FEAT, 32'h0, 33'h0FF, 33'h038);
		apb(1'b0, 8'h3C, 32'h0, 33'h1_FFFF_FFFF, 33'h1_0000_0000);
		apb(1'b0, NBL_OFS_STAT, 32'h0, 33'h003, 33'h000);
		op(NBL_OP_GETF, 32'h00FF_0000, 32'h0038_0000);
		r = $random(seed);
		apb(1'b1, NBL_OFS_ADDR0, r & 32'h0FFF_FFFF, 33'h0, 33'h0);
		apb(1'b1, NBL_OFS_DATA, $random(seed), 33'h0, 33'h0);
		op(NBL_OP_ERASE, 32'h0100_FF00, 32'h0100_6000);
		op(NBL_OP_STAT, 32'h0000_FF00, 32'h0000_6000);
		setf(8'h00);
		op(NBL_OP_GETF, 32'h00FF_0000, 32'h0000_0000);
		// Every two-plane kind on random addresses, all unlocked
		for (i = 1; i <= 4; i++) begin
			apb(1'b1, NBL_OFS_ADDR0, $random(seed), 33'h0, 33'h0);
			apb(1'b1, NBL_OFS_ADDR1, $random(seed), 33'h0, 33'h0);
			op(i[3:0], 32'h0100_FF00, 32'h0000_0000);
		end
		op(NBL_OP_ESTAT, 32'h0000_FF00, 32'h0000_0000);
		// Upper half locked again; one plane upper, one lower
		setf(8'h30);
		r = $random(seed);
		apb(1'b1, NBL_OFS_ADDR0, r & 32'h0FFF_FFFF, 33'h0, 33'h0);
		apb(1'b1, NBL_OFS_ADDR1, r | 32'h1000_0000, 33'h0, 33'h0);
		op(NBL_OP_PROG, 32'h0100_FF00, 32'h0100_6000);
		apb(1'b1, NBL_OFS_ADDR1, r & 32'h0FFF_FFFF, 33'h0, 33'h0);
		op(NBL_OP_PROG, 32'h0100_FF00, 32'h0000_0000);
		// Solid lock refuses a later unlock
		setf(8'h31);
		setf(8'h00);
		op(NBL_OP_GETF, 32'h00FF_0000, 32'h0031_0000);
		apb(1'b1, NBL_OFS_ADDR1, r | 32'h1000_0000, 33'h0, 33'h0);
		op(NBL_OP_PROG, 32'h0100_FF00, 32'h0100_6000);
		checked++;
		if (perr !== 8'h00) begin
			mismatches++;
			$display("ERROR sequence faults exp 0 got %h", perr);
		end
		test_done();
	end
endmodule : nbl_host_test
`default_nettype wire
